//--- logic/motion_event_irq_routing.sv
// routing of internal motion and sensor events onto two pins and the in-band path
// assumes: events are level or pulse inputs synchronous to ref_clk; the
// register port is a simple synchronous write strobe and a read registered one cycle after the address
//
// How it works
// - freefall reaches pin one only while pin-one route bit 7 is set
// - low-g reaches pin one only while pin-one route bit 6 is set
// - step detect reaches pin one only while pin-one route bit 5 is set
// - step overflow reaches pin one only while pin-one route bit 4 is set
// - tilt reaches pin one under bit 3; bits 2..0 reserved, read zero
// - freefall and low-g reach pin two under bits 7 and 6
// - step detect and step overflow reach pin two under bits 5 and 4
// - tilt reaches pin two under bit 3; bits 2..0 reserved
// - frame sync and PLL lock go in-band under bits 5 and 4; 7..6 reserved
// - sample ready goes in-band under sensor route bit 3
// - FIFO threshold and FIFO full go in-band under bits 2 and 1
// - gain-control ready goes in-band under sensor route bit 0
// - bus protocol error goes in-band under motion route bit 7
// - freefall and low-g go in-band under motion route bits 6 and 5
// - significant motion goes in-band under motion route bit 4
// - wake-on-motion Z, Y, X go in-band under bits 3, 2, 1
// - self-test done goes in-band under motion route bit 0
// - all route registers reset to zero, nothing routed until enabled
`timescale 1ns/1ns
`default_nettype none
`include "irq_route_cfg.svh"

module motion_event_irq_routing
(
	input  wire logic       ref_clk,
	input  wire logic       rst,
	// register port
	input  wire logic       reg_wr,
	input  wire logic [7:0] reg_addr,
	input  wire logic [7:0] reg_wdata,
	output var  logic [7:0] reg_rdata,
	// events
	input  wire logic       freefall_event,
	input  wire logic       low_accel_event,
	input  wire logic       step_seen_event,
	input  wire logic       step_overflow_event,
	input  wire logic       tilt_event,
	input  wire logic       frame_sync_event,
	input  wire logic       pll_lock_event,
	input  wire logic       sample_ready_event,
	input  wire logic       fifo_level_event,
	input  wire logic       fifo_full_event,
	input  wire logic       gain_ready_event,
	input  wire logic       bus_error_event,
	input  wire logic       significant_motion_event,
	input  wire logic       wake_on_motion_event_z,
	input  wire logic       wake_on_motion_event_y,
	input  wire logic       wake_on_motion_event_x,
	input  wire logic       selftest_done_event,
	// destinations
	output var  logic       first_irq_pin,
	output var  logic       second_irq_pin,
	output var  logic       inband_irq_req
);

	// ==========================================================
	// route registers
	irq_route_pkg::route_reg_t pin1_motion_event_route;
	irq_route_pkg::route_reg_t pin2_motion_event_route;
	irq_route_pkg::route_reg_t inband_sensor_event_route;
	irq_route_pkg::route_reg_t inband_motion_event_route;

	// reserved bits are masked on write so they always read zero
	always_ff @(posedge ref_clk)
	begin
		if (rst)
			pin1_motion_event_route <= `ROUTE_RESET;
		else if (reg_wr && reg_addr == `PIN1_ROUTE_ADDR)
			pin1_motion_event_route <= reg_wdata & `PIN_WRITE_MASK;
	end

	always_ff @(posedge ref_clk)
	begin
		if (rst)
			pin2_motion_event_route <= `ROUTE_RESET;
		else if (reg_wr && reg_addr == `PIN2_ROUTE_ADDR)
			pin2_motion_event_route <= reg_wdata & `PIN_WRITE_MASK;
	end

	always_ff @(posedge ref_clk)
	begin
		if (rst)
			inband_sensor_event_route <= `ROUTE_RESET;
		else if (reg_wr && reg_addr == `SENSOR_ROUTE_ADDR)
			inband_sensor_event_route <= reg_wdata & `SNS_WRITE_MASK;
	end

	always_ff @(posedge ref_clk)
	begin
		if (rst)
			inband_motion_event_route <= `ROUTE_RESET;
		else if (reg_wr && reg_addr == `MOTION_ROUTE_ADDR)
			inband_motion_event_route <= reg_wdata & `MOT_WRITE_MASK;
	end

	// ==========================================================
	// read-back, registered so the output comes from a flip-flop
	logic [7:0] next_rdata;

	always_comb
	begin
		unique case (reg_addr)
			`PIN1_ROUTE_ADDR:   next_rdata = pin1_motion_event_route;
			`PIN2_ROUTE_ADDR:   next_rdata = pin2_motion_event_route;
			`SENSOR_ROUTE_ADDR: next_rdata = inband_sensor_event_route;
			`MOTION_ROUTE_ADDR: next_rdata = inband_motion_event_route;
			default:            next_rdata = 8'h00;
		endcase
	end

	always_ff @(posedge ref_clk)
	begin
		if (rst)
			reg_rdata <= 8'h00;
		else
			reg_rdata <= next_rdata;
	end

	// ==========================================================
	// gating of events per destination
	logic [4:0] pin1_hits;
	logic [4:0] pin2_hits;
	logic [5:0] sensor_hits;
	logic [7:0] motion_hits;

	always_comb
	begin
		pin1_hits[0] = freefall_event      & pin1_motion_event_route[`PIN_FREEFALL_BIT];
		pin1_hits[1] = low_accel_event     & pin1_motion_event_route[`PIN_LOW_ACCEL_BIT];
		pin1_hits[2] = step_seen_event     & pin1_motion_event_route[`PIN_STEP_SEEN_BIT];
		pin1_hits[3] = step_overflow_event & pin1_motion_event_route[`PIN_STEP_OVF_BIT];
		pin1_hits[4] = tilt_event          & pin1_motion_event_route[`PIN_TILT_BIT];
	end

	always_comb
	begin
		pin2_hits[0] = freefall_event      & pin2_motion_event_route[`PIN_FREEFALL_BIT];
		pin2_hits[1] = low_accel_event     & pin2_motion_event_route[`PIN_LOW_ACCEL_BIT];
		pin2_hits[2] = step_seen_event     & pin2_motion_event_route[`PIN_STEP_SEEN_BIT];
		pin2_hits[3] = step_overflow_event & pin2_motion_event_route[`PIN_STEP_OVF_BIT];
		pin2_hits[4] = tilt_event          & pin2_motion_event_route[`PIN_TILT_BIT];
	end

	always_comb
	begin
		sensor_hits[0] = frame_sync_event   & inband_sensor_event_route[`SNS_FRAME_SYNC_BIT];
		sensor_hits[1] = pll_lock_event     & inband_sensor_event_route[`SNS_PLL_LOCK_BIT];
		sensor_hits[2] = sample_ready_event & inband_sensor_event_route[`SNS_SAMPLE_BIT];
		sensor_hits[3] = fifo_level_event   & inband_sensor_event_route[`SNS_FIFO_LVL_BIT];
		sensor_hits[4] = fifo_full_event    & inband_sensor_event_route[`SNS_FIFO_FULL_BIT];
		sensor_hits[5] = gain_ready_event   & inband_sensor_event_route[`SNS_GAIN_BIT];
	end

	always_comb
	begin
		motion_hits[0] = bus_error_event & inband_motion_event_route[`MOT_BUS_ERR_BIT];
		motion_hits[1] = freefall_event  & inband_motion_event_route[`MOT_FREEFALL_BIT];
		motion_hits[2] = low_accel_event & inband_motion_event_route[`MOT_LOW_ACCEL_BIT];
		motion_hits[3] = significant_motion_event
			& inband_motion_event_route[`MOT_SIG_MOTION_BIT];
		motion_hits[4] = wake_on_motion_event_z
			& inband_motion_event_route[`MOT_WAKE_Z_BIT];
		motion_hits[5] = wake_on_motion_event_y
			& inband_motion_event_route[`MOT_WAKE_Y_BIT];
		motion_hits[6] = wake_on_motion_event_x
			& inband_motion_event_route[`MOT_WAKE_X_BIT];
		motion_hits[7] = selftest_done_event
			& inband_motion_event_route[`MOT_SELFTEST_BIT];
	end

	// ==========================================================
	// destination outputs; one cycle of latency buys glitch-free pins
	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			first_irq_pin  <= 1'b0;
			second_irq_pin <= 1'b0;
			inband_irq_req <= 1'b0;
		end
		else
		begin
			first_irq_pin  <= |pin1_hits;
			second_irq_pin <= |pin2_hits;
			inband_irq_req <= (|sensor_hits) | (|motion_hits);
		end
	end

endmodule

`default_nettype wire

//--- common/irq_route_cfg.svh
// register offsets, field positions and reset values of the event routing block
// assumes: included by bare name from the design
`ifndef IRQ_ROUTE_CFG_SVH
`define IRQ_ROUTE_CFG_SVH

`define PIN1_ROUTE_ADDR    8'h2F
`define PIN2_ROUTE_ADDR    8'h30
`define SENSOR_ROUTE_ADDR  8'h31
`define MOTION_ROUTE_ADDR  8'h32
`define ROUTE_RESET        8'h00

// pin routing fields
`define PIN_FREEFALL_BIT   7
`define PIN_LOW_ACCEL_BIT  6
`define PIN_STEP_SEEN_BIT  5
`define PIN_STEP_OVF_BIT   4
`define PIN_TILT_BIT       3
`define PIN_WRITE_MASK     8'hF8

// in-band sensor routing fields
`define SNS_FRAME_SYNC_BIT 5
`define SNS_PLL_LOCK_BIT   4
`define SNS_SAMPLE_BIT     3
`define SNS_FIFO_LVL_BIT   2
`define SNS_FIFO_FULL_BIT  1
`define SNS_GAIN_BIT       0
`define SNS_WRITE_MASK     8'h3F

// in-band motion routing fields
`define MOT_BUS_ERR_BIT    7
`define MOT_FREEFALL_BIT   6
`define MOT_LOW_ACCEL_BIT  5
`define MOT_SIG_MOTION_BIT 4
`define MOT_WAKE_Z_BIT     3
`define MOT_WAKE_Y_BIT     2
`define MOT_WAKE_X_BIT     1
`define MOT_SELFTEST_BIT   0
`define MOT_WRITE_MASK     8'hFF

`endif

//--- common/irq_route_pkg.sv
// types of the event routing block
// assumes: nothing beyond the cfg header
package irq_route_pkg;
	typedef logic [7:0] route_reg_t;
	typedef logic [7:0] reg_addr_t;
endpackage

//--- tb/irq_route_sva.sv
// port checker of the event routing block
// assumes: bound onto motion_event_irq_routing, ports matched by name
`timescale 1ns/1ns
`default_nettype none
module irq_route_sva
(
	input wire logic       ref_clk, rst, reg_wr, first_irq_pin, second_irq_pin, inband_irq_req,
	input wire logic [7:0] reg_addr, reg_wdata, reg_rdata,
	input wire logic       freefall_event, low_accel_event, step_seen_event, step_overflow_event,
	input wire logic       tilt_event, frame_sync_event, pll_lock_event, sample_ready_event,
	input wire logic       fifo_level_event, fifo_full_event, gain_ready_event, bus_error_event,
	input wire logic       significant_motion_event, wake_on_motion_event_z,
	input wire logic       wake_on_motion_event_y, wake_on_motion_event_x, selftest_done_event
);
	// ====
	// shadow registers; rst gates the helpers so a mid-run reset never fires
	logic [7:0] r1, r2, rs, rm, rd;
	logic [4:0] pe;
	logic       p1, p2, ib;
	always_ff @(posedge ref_clk)
	begin
		r1 <= rst ? 8'h00 : (reg_wr && reg_addr == 8'h2F) ? reg_wdata & 8'hF8 : r1;
		r2 <= rst ? 8'h00 : (reg_wr && reg_addr == 8'h30) ? reg_wdata & 8'hF8 : r2;
		rs <= rst ? 8'h00 : (reg_wr && reg_addr == 8'h31) ? reg_wdata & 8'h3F : rs;
		rm <= rst ? 8'h00 : (reg_wr && reg_addr == 8'h32) ? reg_wdata : rm;
	end
	assign rd = rst ? 8'h00 : reg_addr == 8'h2F ? r1 : reg_addr == 8'h30 ? r2
		: reg_addr == 8'h31 ? rs : reg_addr == 8'h32 ? rm : 8'h00;
	assign pe = {freefall_event, low_accel_event, step_seen_event, step_overflow_event, tilt_event};
	assign p1 = !rst && (|(pe & r1[7:3]));
	assign p2 = !rst && (|(pe & r2[7:3]));
	assign ib = !rst && (|({frame_sync_event, pll_lock_event, sample_ready_event, fifo_level_event,
		fifo_full_event, gain_ready_event} & rs[5:0]) || |({bus_error_event, freefall_event,
		low_accel_event, significant_motion_event, wake_on_motion_event_z, wake_on_motion_event_y,
		wake_on_motion_event_x, selftest_done_event} & rm));
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	AST_PIN1: assert property (first_irq_pin == $past(p1)) else $error("pin one");
	AST_PIN2: assert property (second_irq_pin == $past(p2)) else $error("pin two");
	AST_INBAND: assert property (inband_irq_req == $past(ib)) else $error("inband");
	AST_READ: assert property (reg_rdata == $past(rd)) else $error("read data");
	AST_RSV_PIN: assert property ($past(reg_addr) inside {8'h2F, 8'h30} |->
		reg_rdata[2:0] == 3'h0) else $error("pin reserved");
	AST_RSV_SNS: assert property ($past(reg_addr) == 8'h31 |-> reg_rdata[7:6] == 2'h0)
		else $error("sensor reserved");
	AST_RST: assert property ($fell(rst) |-> !(first_irq_pin || second_irq_pin || inband_irq_req))
		else $error("reset outputs");
	AST_MULTI: assert property (freefall_event && r1[7] && r2[7] && rm[6] |=>
		first_irq_pin && second_irq_pin && inband_irq_req) else $error("multi route");
	cover property (first_irq_pin && second_irq_pin);
	cover property (inband_irq_req && !first_irq_pin);
	cover property (reg_wr && reg_addr == 8'h32);
endmodule
`default_nettype wire

//--- tb/host_irq_sink.sv
// host side: tallies cycles in which any interrupt line is raised
// assumes: lines are levels synchronous to ref_clk
`timescale 1ns/1ns
`default_nettype none
module host_irq_sink
(
	input  wire logic        ref_clk, rst, first_irq_pin, second_irq_pin, inband_irq_req,
	output var  logic [15:0] seen
);
	// ====
	// levels need no acknowledge, so the host only counts them
	initial seen = 16'h0000;
	always @(posedge ref_clk)
		if (!rst)
			seen <= seen + 16'(first_irq_pin || second_irq_pin || inband_irq_req);
endmodule
`default_nettype wire

//--- tb/tb.sv
// bench of the event routing block: random traffic against a behavioural model
// assumes: design, checker and host sink compiled first
`timescale 1ns/1ns
`default_nettype none
module tb;
	logic        ref_clk, rst, reg_wr, first_irq_pin, second_irq_pin, inband_irq_req;
	logic [7:0]  reg_addr, reg_wdata, reg_rdata;
	logic [16:0] ev;
	logic [15:0] seen, e1, e2, ei, erd;
	int          mreg[4], mask[4] = '{8'hF8, 8'hF8, 8'h3F, 8'hFF};
	int          k, exp_seen, cycles, bad_count, n_compared;
	motion_event_irq_routing i_dut
	(
		.ref_clk, .rst, .reg_wr, .reg_addr, .reg_wdata, .reg_rdata, .first_irq_pin,
		.second_irq_pin, .inband_irq_req, .freefall_event(ev[16]), .low_accel_event(ev[15]),
		.step_seen_event(ev[14]), .step_overflow_event(ev[13]), .tilt_event(ev[12]),
		.frame_sync_event(ev[11]), .pll_lock_event(ev[10]), .sample_ready_event(ev[9]),
		.fifo_level_event(ev[8]), .fifo_full_event(ev[7]), .gain_ready_event(ev[6]),
		.bus_error_event(ev[5]), .significant_motion_event(ev[4]), .wake_on_motion_event_z(ev[3]),
		.wake_on_motion_event_y(ev[2]), .wake_on_motion_event_x(ev[1]), .selftest_done_event(ev[0])
	);
	host_irq_sink i_host (.ref_clk, .rst, .first_irq_pin, .second_irq_pin, .inband_irq_req, .seen);
	// ====
	// model: outputs one edge late, read data of the old value
	always @(posedge ref_clk)
	begin
		if (rst)
			mreg = '{0, 0, 0, 0};
		k = int'(reg_addr) - 8'h2F;
		e1 = 16'(|(ev[16:12] & mreg[0][7:3]));
		e2 = 16'(|(ev[16:12] & mreg[1][7:3]));
		ei = 16'(|(ev[11:6] & mreg[2][5:0]) || |({ev[5], ev[16:15], ev[4:0]} & mreg[3][7:0]));
		erd = (k >= 0 && k < 4) ? 16'(mreg[k]) : 16'h0000;
		if (!rst && reg_wr && k >= 0 && k < 4)
			mreg[k] = reg_wdata & mask[k];
	end
	initial
	begin
		ref_clk = 0;
		forever #25 ref_clk = ~ref_clk;
	end
	always @(posedge ref_clk)
		if (++cycles == 2500)
			end_sim(1);
	task automatic cmp(input logic [15:0] got, input logic [15:0] want);
		n_compared++;
		if (got !== want)
		begin
			bad_count++;
			$display("[FAIL] %0t got %h want %h", $time, got, want);
		end
	endtask
	task automatic end_sim(input int extra);
		bad_count += extra;
		$display("compared %0d mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	initial
	begin
		{rst, reg_wr, reg_addr, reg_wdata, ev} = {2'b10, 33'h000000000};
		void'($urandom(32'h8D41E8A3));
		repeat (3) @(posedge ref_clk);
		for (int i = 0; i < 2000; i++)
		begin
			@(negedge ref_clk);
			cmp(first_irq_pin, e1);
			cmp(second_irq_pin, e2);
			cmp(inband_irq_req, ei);
			cmp(reg_rdata, erd);
			// one extra reset mid-run, unmapped addresses mixed in
			rst = (i == 1000);
			ev = 17'($urandom & $urandom & $urandom);
			reg_wr = ($urandom % 3) == 0;
			reg_addr = 8'h2E + 8'($urandom % 6);
			reg_wdata = 8'($urandom);
			exp_seen += int'(!rst && (e1 || e2 || ei));
		end
		@(posedge ref_clk);
		#1;
		cmp(seen, 16'(exp_seen));
		end_sim(0);
	end
endmodule
bind motion_event_irq_routing irq_route_sva i_sva (.*);
`default_nettype wire
